// [design/orp_pkg.sv]
package orp_pkg;
  // ----------------------------------------
  // Geometry of the OTP space
  // ----------------------------------------
  localparam int unsigned OTP_BYTES      = 1024;
  localparam int unsigned OTP_ADDR_W     = 10;
  localparam int unsigned REGION_COUNT   = 32;
  localparam int unsigned REGION_BYTES   = 32;
  localparam int unsigned REGION_SHIFT   = 5;
  localparam logic [9:0]  RANDOM_LAST    = 10'h00F;
  localparam logic [9:0]  LOCK_FIRST     = 10'h010;
  localparam logic [9:0]  LOCK_LAST      = 10'h013;
  localparam logic [9:0]  RESERVED_FIRST = 10'h014;
  localparam logic [9:0]  RESERVED_LAST  = 10'h01F;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [7:0]  DEFAULT_RANDOM = 8'h5A;  // Arbitrary factory pattern seed

  // ----------------------------------------
  // Identification space
  // ----------------------------------------
  localparam int unsigned ID_ADDR_W      = 7;
  localparam int unsigned ID_BYTES       = 128;
  localparam logic [7:0]  ID_SEED        = 8'h3C;  // Arbitrary content, not a real code
  localparam logic [7:0]  READ_ID_OPCODE = 8'h9F;

  // ----------------------------------------
  // Register fields and defaults
  // ----------------------------------------
  localparam int unsigned CFG_FREEZE_BIT = 0;
  localparam int unsigned STS_PERR_BIT   = 6;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic        PERR_RESET     = 1'b0;

  typedef enum logic [1:0] {
    ORP_CMD_NONE,
    ORP_CMD_READ_ID,
    ORP_CMD_READ_OTP,
    ORP_CMD_PROG_OTP
  } orp_cmd_t;
endpackage

// [design/orp_otp_array.sv]
`timescale 1ns/100ps
`default_nettype none
module orp_otp_array
  import orp_pkg::*;
(
  input  wire logic                  clk,       // System clock
  input  wire logic [OTP_ADDR_W-1:0] rdAddr,    // Read byte address
  output logic      [7:0]            rdData,    // Registered read byte
  input  wire logic                  wrEn,      // Program strobe, already permitted
  input  wire logic [OTP_ADDR_W-1:0] wrAddr,    // Program byte address
  input  wire logic [7:0]            wrData,    // Bits to program
  output logic      [31:0]           lockBits   // Lock bytes 010h to 013h
);
  import orp_pkg::*;

  // ----------------------------------------
  // Storage, nonvolatile: no reset
  // ----------------------------------------
  typedef logic [7:0] orp_image_t [OTP_BYTES];

  // Random number in bytes 000h-00Fh, least significant first; rest erased
  function automatic orp_image_t factoryImage();
    orp_image_t img;
    for (int i = 0; i < OTP_BYTES; i++) begin
      if (i <= int'(RANDOM_LAST)) begin
        img[i] = DEFAULT_RANDOM ^ 8'(i);
      end else begin
        img[i] = ERASED_BYTE;
      end
    end
    return img;
  endfunction

  // Image given at declaration so that only the clocked process writes the array
  logic [7:0] mem [OTP_BYTES] = factoryImage();
  logic [7:0] next_rdData;

  always_comb begin
    next_rdData = mem[rdAddr];
  end

  // Program only pulls ones to zero; there is no erase path
  always_ff @(posedge clk) begin
    rdData <= next_rdData;
    if (wrEn) begin
      mem[wrAddr] <= mem[wrAddr] & wrData;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLock
      assign lockBits[8*g +: 8] = mem[int'(LOCK_FIRST) + g];
    end
  endgenerate

endmodule
`default_nettype wire

// [design/orp_otp_protect.sv]
`timescale 1ns/100ps
`default_nettype none
module orp_otp_protect
  import orp_pkg::*;
(
  input  wire logic                  clk,            // 250 MHz clock
  input  wire logic                  rst_n,          // Async reset, any reset source
  input  wire orp_pkg::orp_cmd_t     cmd,            // Decoded command, one-cycle
  input  wire logic [OTP_ADDR_W-1:0] cmdAddr,        // OTP or identification address
  input  wire logic [7:0]            cmdData,        // Byte to program
  input  wire logic                  writeCfgStrobe, // Write-registers command pulse
  input  wire logic [7:0]            writeCfgData,   // New configuration value
  input  wire logic                  clearStatus,    // Clear-status command pulse
  output logic      [7:0]            readData,       // Read byte
  output logic                       readValid,      // Read byte valid pulse
  output logic                       progDone,       // Program accepted pulse
  output logic                       progReject,     // Program refused pulse
  output logic      [7:0]            configRegOne,   // Configuration register one
  output logic      [7:0]            statusRegOne    // Status register one
);
  import orp_pkg::*;

  // ----------------------------------------
  // Identification space, fixed content
  // ----------------------------------------
  function automatic logic [7:0] idByte(input logic [ID_ADDR_W-1:0] a);
    idByte = ID_SEED ^ {1'b0, a};
  endfunction

  // ----------------------------------------
  // OTP storage
  // ----------------------------------------
  logic        wrEn;
  logic [7:0]  otpRdData;
  logic [31:0] lockBits;

  orp_otp_array uArray (
    .clk      (clk),
    .rdAddr   (cmdAddr),
    .rdData   (otpRdData),
    .wrEn     (wrEn),
    .wrAddr   (cmdAddr),
    .wrData   (cmdData),
    .lockBits (lockBits)
  );

  // ----------------------------------------
  // Program permission
  // ----------------------------------------
  logic [4:0] region;
  logic       isProg;
  logic       inRandom;
  logic       regionLocked;
  logic       frozen;
  logic       allowed;

  always_comb begin
    region       = cmdAddr[OTP_ADDR_W-1 -: 5];
    isProg       = (cmd == ORP_CMD_PROG_OTP);
    inRandom     = (cmdAddr <= RANDOM_LAST);
    regionLocked = ~lockBits[region];
    frozen       = configRegOne[CFG_FREEZE_BIT];
    // Reserved bytes fall through to region 0 rules and stay programmable
    allowed      = ~inRandom & ~regionLocked & ~frozen;
    wrEn         = isProg & allowed;
  end

  // ----------------------------------------
  // Volatile registers and responses
  // ----------------------------------------
  logic       perr;
  logic       next_perr;
  logic [7:0] next_cfg;
  logic       rdPend;
  logic       next_rdPend;
  logic       idPend;
  logic       next_idPend;
  logic [7:0] idHold;
  logic [7:0] next_idHold;
  logic       next_progDone;
  logic       next_progReject;

  always_comb begin
    next_cfg = configRegOne;
    // Freeze is sticky: a write may set it, never clear it
    if (writeCfgStrobe) begin
      next_cfg = writeCfgData;
      next_cfg[CFG_FREEZE_BIT] = writeCfgData[CFG_FREEZE_BIT] | frozen;
    end
    next_perr = perr;
    if (clearStatus) begin
      next_perr = 1'b0;
    end
    // Set wins over a clear arriving in the same cycle
    if (isProg && !allowed) begin
      next_perr = 1'b1;
    end
    next_progDone   = wrEn;
    next_progReject = isProg & ~allowed;
    next_rdPend     = (cmd == ORP_CMD_READ_OTP);
    next_idPend     = (cmd == ORP_CMD_READ_ID);
    next_idHold     = idByte(cmdAddr[ID_ADDR_W-1:0]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      configRegOne <= CFG_RESET;
      perr         <= PERR_RESET;
      progDone     <= 1'b0;
      progReject   <= 1'b0;
      rdPend       <= 1'b0;
      idPend       <= 1'b0;
      idHold       <= 8'h00;
    end else begin
      configRegOne <= next_cfg;
      perr         <= next_perr;
      progDone     <= next_progDone;
      progReject   <= next_progReject;
      rdPend       <= next_rdPend;
      idPend       <= next_idPend;
      idHold       <= next_idHold;
    end
  end

  always_comb begin
    statusRegOne               = 8'h00;
    statusRegOne[STS_PERR_BIT] = perr;
    readValid                  = rdPend | idPend;
    // OTP reads use the array's registered byte, id reads the held byte
    readData                   = idPend ? idHold : (rdPend ? otpRdData : 8'h00);
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_badProg;
    isProg && !allowed;
  endsequence

  property p_perrSet;
    @(posedge clk) disable iff (!rst_n) s_badProg |=> perr && progReject;
  endproperty
  a_perrSet: assert property (p_perrSet) else $error("program error not flagged");

  property p_frozenNoWrite;
    @(posedge clk) disable iff (!rst_n) frozen |-> !wrEn;
  endproperty
  a_frozenNoWrite: assert property (p_frozenNoWrite) else $error("write while frozen");

  property p_freezeSticky;
    @(posedge clk) disable iff (!rst_n) frozen |=> frozen;
  endproperty
  a_freezeSticky: assert property (p_freezeSticky) else $error("freeze bit cleared");

  property p_randomRefused;
    @(posedge clk) disable iff (!rst_n)
      isProg && cmdAddr <= RANDOM_LAST |=> progReject && !progDone;
  endproperty
  a_randomRefused: assert property (p_randomRefused) else $error("random bytes programmed");

  property p_lockedRefused;
    @(posedge clk) disable iff (!rst_n) isProg && !lockBits[region] |=> progReject;
  endproperty
  a_lockedRefused: assert property (p_lockedRefused) else $error("locked region programmed");

  property p_perrHolds;
    @(posedge clk) disable iff (!rst_n) perr && !clearStatus |=> perr;
  endproperty
  a_perrHolds: assert property (p_perrHolds) else $error("program error lost");

  property p_readTwo;
    @(posedge clk) disable iff (!rst_n) cmd == ORP_CMD_READ_ID |=> readValid && readData == $past(next_idHold);
  endproperty
  a_readTwo: assert property (p_readTwo) else $error("id read wrong");

  property p_readOtp;
    @(posedge clk) disable iff (!rst_n)
      cmd == ORP_CMD_READ_OTP |=> readValid && readData == otpRdData && !progDone;
  endproperty
  a_readOtp: assert property (p_readOtp) else $error("otp read wrong");

  sequence s_goodProg;
    isProg && allowed;
  endsequence

  property p_goodProg;
    @(posedge clk) disable iff (!rst_n)
      s_goodProg |=> progDone && !progReject && ($stable(perr) || $past(clearStatus));
  endproperty
  a_goodProg: assert property (p_goodProg) else $error("allowed program refused");

  property p_lockWord;
    @(posedge clk) disable iff (!rst_n) wrEn && cmdAddr == LOCK_FIRST |=> (lockBits[7:0] & ~$past(lockBits[7:0])) == 8'h00;
  endproperty
  a_lockWord: assert property (p_lockWord) else $error("lock bit returned to one");

  property p_clearPerr;
    @(posedge clk) disable iff (!rst_n) clearStatus && !(isProg && !allowed) |=> !perr;
  endproperty
  a_clearPerr: assert property (p_clearPerr) else $error("program error not cleared");

  property p_idleQuiet;
    @(posedge clk) disable iff (!rst_n)
      cmd == ORP_CMD_NONE |=> !readValid && !progDone && !progReject;
  endproperty
  a_idleQuiet: assert property (p_idleQuiet) else $error("response without command");

  property p_reservedOpen;
    @(posedge clk) disable iff (!rst_n)
      isProg && cmdAddr >= RESERVED_FIRST && cmdAddr <= RESERVED_LAST && lockBits[0] && !frozen
      |=> progDone;
  endproperty
  a_reservedOpen: assert property (p_reservedOpen) else $error("reserved byte refused");

  property p_cfgWrite;
    @(posedge clk) disable iff (!rst_n)
      writeCfgStrobe |=> configRegOne[7:1] == $past(writeCfgData[7:1]);
  endproperty
  a_cfgWrite: assert property (p_cfgWrite) else $error("configuration not loaded");

endmodule
`default_nettype wire

// [dv/orp_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module orp_host_model
  import orp_pkg::*;
(
  input  wire logic        clk,            // Clock
  input  wire logic [7:0]  readData,       // Read byte
  input  wire logic        readValid,      // Read pulse
  input  wire logic        progDone,       // Accept pulse
  input  wire logic        progReject,     // Refuse pulse
  output var  orp_cmd_t    cmd,            // Command
  output var  logic [9:0]  cmdAddr,        // Address
  output var  logic [7:0]  cmdData,        // Program byte
  output var  logic        writeCfgStrobe, // Config write
  output var  logic [7:0]  writeCfgData,   // Config value
  output var  logic        clearStatus     // Clear status
);
  import orp_pkg::*;

  initial begin
    cmd = ORP_CMD_NONE;
    cmdAddr = 10'h000;
    cmdData = 8'h00;
    writeCfgStrobe = 1'b0;
    writeCfgData = 8'h00;
    clearStatus = 1'b0;
  end
  // ----------------------------------------
  // Command tasks
  // ----------------------------------------
  // Released fields flip so a stale value is never mistaken for a live one
  task automatic issue(input orp_cmd_t c, input logic [9:0] a, input logic [7:0] d,
                       output logic [7:0] rd, output logic ok, output logic rj);
    @(posedge clk);
    cmd <= c;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge clk);
    cmd <= ORP_CMD_NONE;
    cmdAddr <= ~a;
    cmdData <= ~d;
    #1;
    rd = readData;
    ok = (c == ORP_CMD_PROG_OTP) ? progDone : readValid;
    rj = progReject;
  endtask
  task automatic cfg(input logic [7:0] v);
    @(posedge clk);
    writeCfgStrobe <= 1'b1;
    writeCfgData <= v;
    @(posedge clk);
    writeCfgStrobe <= 1'b0;
    writeCfgData <= ~v;
  endtask
  task automatic clear();
    @(posedge clk);
    clearStatus <= 1'b1;
    @(posedge clk);
    clearStatus <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/test_orp_otp_protect.sv]
`timescale 1ns/100ps
`default_nettype none
module test_orp_otp_protect;
  import orp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  orp_cmd_t cmd;
  logic [9:0] cmdAddr;
  logic [7:0] cmdData, writeCfgData, readData, configRegOne, statusRegOne, rd;
  logic writeCfgStrobe, clearStatus, readValid, progDone, progReject, ok, rj;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  orp_otp_protect orp_otp_protect_inst (.clk(clk), .rst_n(rst_n), .cmd(cmd),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .writeCfgStrobe(writeCfgStrobe),
    .writeCfgData(writeCfgData), .clearStatus(clearStatus), .readData(readData),
    .readValid(readValid), .progDone(progDone), .progReject(progReject),
    .configRegOne(configRegOne), .statusRegOne(statusRegOne));
  orp_host_model orp_host_model_inst (.clk(clk), .readData(readData),
    .readValid(readValid), .progDone(progDone), .progReject(progReject), .cmd(cmd),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .writeCfgStrobe(writeCfgStrobe),
    .writeCfgData(writeCfgData), .clearStatus(clearStatus));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic op(input orp_cmd_t c, input logic [9:0] a, input logic [7:0] d);
    orp_host_model_inst.issue(c, a, d, rd, ok, rj);
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Program responses are packed as {ok, rj}: 02 accepted, 01 refused
  task automatic t_spaces();
    chk(configRegOne, CFG_RESET);
    chk(statusRegOne, 8'h00);
    op(ORP_CMD_READ_OTP, 10'h003, 8'hFF);
    chk(rd, DEFAULT_RANDOM ^ 8'h03);
    chk({7'h00, ok}, 8'h01);
    op(ORP_CMD_READ_ID, 10'h003, 8'hFF);
    chk(rd, ID_SEED ^ 8'h03);
    chk({7'h00, ok}, 8'h01);
    op(ORP_CMD_READ_ID, 10'h07F, 8'h00);
    chk(rd, ID_SEED ^ 8'h7F);
    op(ORP_CMD_READ_OTP, 10'h013, 8'h00);
    chk(rd, ERASED_BYTE);
  endtask
  task automatic t_prog();
    op(ORP_CMD_READ_OTP, 10'h020, 8'h00);
    chk(rd, ERASED_BYTE);
    op(ORP_CMD_PROG_OTP, 10'h020, 8'hA5);
    chk({6'h00, ok, rj}, 8'h02);
    op(ORP_CMD_PROG_OTP, 10'h020, 8'h0F);
    op(ORP_CMD_READ_OTP, 10'h020, 8'h00);
    chk(rd, 8'h05);
    op(ORP_CMD_PROG_OTP, 10'h3FF, 8'h3C);
    op(ORP_CMD_READ_OTP, 10'h3FF, 8'h00);
    chk(rd, 8'h3C);
    op(ORP_CMD_PROG_OTP, 10'h01F, 8'h00);
    chk({6'h00, ok, rj}, 8'h02);
    op(ORP_CMD_READ_OTP, 10'h01F, 8'h00);
    chk(rd, 8'h00);
  endtask
  task automatic t_refuse();
    op(ORP_CMD_PROG_OTP, 10'h00F, 8'h00);
    chk({6'h00, ok, rj}, 8'h01);
    settle();
    chk(statusRegOne, 8'h40);
    op(ORP_CMD_READ_OTP, 10'h00F, 8'h00);
    chk(rd, DEFAULT_RANDOM ^ 8'h0F);
    orp_host_model_inst.clear();
    settle();
    chk(statusRegOne, 8'h00);
    // Refused program and clear-status in one cycle: the error must stay set
    fork
      op(ORP_CMD_PROG_OTP, 10'h000, 8'h00);
      orp_host_model_inst.clear();
    join
    chk(statusRegOne, 8'h40);
    orp_host_model_inst.clear();
    settle();
    chk(statusRegOne, 8'h00);
  endtask
  task automatic t_lock();
    op(ORP_CMD_PROG_OTP, 10'h010, 8'hFD);
    op(ORP_CMD_PROG_OTP, 10'h021, 8'h00);
    chk({6'h00, ok, rj}, 8'h01);
    op(ORP_CMD_PROG_OTP, 10'h040, 8'h00);
    chk({6'h00, ok, rj}, 8'h02);
    op(ORP_CMD_PROG_OTP, 10'h013, 8'h7F);
    op(ORP_CMD_PROG_OTP, 10'h3E0, 8'h00);
    chk({6'h00, ok, rj}, 8'h01);
    op(ORP_CMD_PROG_OTP, 10'h3DF, 8'h00);
    chk({6'h00, ok, rj}, 8'h02);
    op(ORP_CMD_PROG_OTP, 10'h010, 8'hFF);
    op(ORP_CMD_READ_OTP, 10'h010, 8'h00);
    chk(rd, 8'hFD);
  endtask
  task automatic t_freeze();
    orp_host_model_inst.cfg(8'h01);
    settle();
    chk(configRegOne, 8'h01);
    op(ORP_CMD_PROG_OTP, 10'h060, 8'h00);
    chk({6'h00, ok, rj}, 8'h01);
    orp_host_model_inst.cfg(8'h00);
    settle();
    chk(configRegOne, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(configRegOne, CFG_RESET);
    chk(statusRegOne, 8'h00);
    op(ORP_CMD_READ_OTP, 10'h020, 8'h00);
    chk(rd, 8'h05);
    op(ORP_CMD_PROG_OTP, 10'h060, 8'h00);
    chk({6'h00, ok, rj}, 8'h02);
  endtask
  // ----------------------------------------
  // Sequence and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_spaces();
    t_prog();
    t_refuse();
    t_lock();
    t_freeze();
    conclude();
  end
endmodule
`default_nettype wire
